// ==== core/pport_regs.sv ====
// parallel port host registers with enhanced strobe engine
`timescale 1ns/1ps
module pport_regs (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire pport_pkg::port_mode_type port_mode,
  input wire logic legacy_addressing,
  input wire logic [9:0] base_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [2:0] bus_addr,
  input wire logic [1:0] bus_size,
  input wire logic [31:0] bus_wdata,
  output logic [31:0] bus_rdata,
  output logic bus_done,
  output logic bus_ready,
  input wire logic paper_end_in,
  input wire logic ack_in,
  input wire logic busy_in,
  input wire logic error_in,
  input wire logic select_in,
  input wire logic strobe_pin_in,
  input wire logic feed_pin_in,
  input wire logic init_pin_in,
  input wire logic select_pin_in,
  input wire logic [7:0] port_data_in,
  output logic [7:0] port_data_lines,
  output logic port_data_oe,
  output logic data_strobe_out,
  output logic auto_feed_out,
  output logic init_out,
  output logic select_request_out,
  output logic control_oe,
  output logic address_strobe_out,
  output logic data_strobe_epp_out,
  output logic write_n_out,
  output logic port_interrupt,
  output logic port_interrupt_oe
);
  import pport_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0] ctl;
    logic [7:0] data_latch;
    logic timeout, irq_stat, irq, irq_oe, ack_prev;
    port_mode_type mode_prev;
    xfer_state_type st;
    logic [1:0] byte_idx, byte_last;
    logic is_write, is_addr;
    logic [TMO_W-1:0] tmo_cnt;
    logic [31:0] wbuf, rbuf, rdata;
    logic done, ready, strb_a, strb_d, write_n;
    logic [7:0] pd_out;
    logic pd_oe, pin_stb, pin_feed, pin_init, pin_sel, ctl_oe;
  } state_type;

  state_type s_q, s_d;
  logic enh_ok, enh_mode, ext_like, enh_acc, ack_rise, tmo_event;
  logic [7:0] status_val, control_val;

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  assign enh_ok = (base_addr[2:0] == 3'h0)
    && !(legacy_addressing && base_addr == BASE_NO_ENHANCED);
  assign enh_mode = (port_mode == MODE_ENHANCED) && enh_ok;
  assign ext_like = (port_mode == MODE_EXTENDED) || enh_mode;
  assign enh_acc = enh_mode && (bus_addr >= OFS_TARGET);
  assign ack_rise = ack_in && !s_q.ack_prev;

  // ----------------------------------------------------------------
  // read values
  // ----------------------------------------------------------------
  always_comb begin
    status_val = 8'h00;
    status_val[STS_BUSY_BIT] = !busy_in;
    status_val[STS_ACK_BIT] = ack_in;
    status_val[STS_PAPER_BIT] = paper_end_in;
    status_val[4] = select_in;
    status_val[3] = error_in;
    status_val[STS_IRQ_BIT] = s_q.irq_stat;
    status_val[1] = 1'b1;
    status_val[STS_TIMEOUT_BIT] = enh_mode ? s_q.timeout : 1'b1;
    control_val = {CTL_RSVD_VALUE, 6'h00};
    control_val[CTL_DIR_BIT] = enh_mode ? s_q.ctl[CTL_DIR_BIT] : 1'b1;
    control_val[CTL_IRQ_EN_BIT] = s_q.ctl[CTL_IRQ_EN_BIT];
    control_val[CTL_SELECT_BIT] = !select_pin_in;
    control_val[CTL_INIT_BIT] = init_pin_in;
    control_val[CTL_FEED_BIT] = !feed_pin_in;
    control_val[CTL_STROBE_BIT] = !strobe_pin_in;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    tmo_event = 1'b0;
    s_d.done = 1'b0;
    s_d.ack_prev = ack_in;
    s_d.mode_prev = port_mode;
    s_d.ctl_oe = 1'b1;
    if (enh_mode && s_q.mode_prev != MODE_ENHANCED) s_d.timeout = 1'b0;
    case (s_q.st)
      ST_IDLE: begin
        if ((bus_rd || bus_wr) && enh_acc) begin
          s_d.st = ST_STROBE;
          s_d.is_write = bus_wr;
          s_d.is_addr = (bus_addr == OFS_TARGET);
          s_d.byte_idx = 2'h0;
          s_d.byte_last = 2'h0;
          if (bus_addr == OFS_XFER0 && bus_size == SIZE_WORD) s_d.byte_last = 2'h1;
          if (bus_addr == OFS_XFER0 && bus_size == SIZE_DWORD) s_d.byte_last = 2'h3;
          s_d.wbuf = bus_wdata;
          s_d.rbuf = 32'h0000_0000;
          s_d.tmo_cnt = '0;
          s_d.ready = 1'b0;
          s_d.write_n = !bus_wr;
          s_d.pd_oe = bus_wr;
          s_d.pd_out = bus_wdata[7:0];
          s_d.strb_a = (bus_addr == OFS_TARGET);
          s_d.strb_d = (bus_addr != OFS_TARGET);
        end else if (bus_rd) begin
          s_d.done = 1'b1;
          s_d.rdata = {24'h00_0000, UNMAPPED_VALUE};
          case (bus_addr)
            OFS_DATA_LATCH: begin
              s_d.rdata[7:0] = (ext_like && s_q.ctl[CTL_DIR_BIT]) ?
                port_data_in : s_q.data_latch;
            end
            OFS_STATUS: begin
              s_d.rdata[7:0] = status_val;
              s_d.timeout = 1'b0;
              s_d.irq_stat = 1'b1;
            end
            OFS_CONTROL: s_d.rdata[7:0] = control_val;
            default: s_d.rdata[7:0] = UNMAPPED_VALUE;
          endcase
        end else if (bus_wr) begin
          s_d.done = 1'b1;
          case (bus_addr)
            OFS_DATA_LATCH: s_d.data_latch = bus_wdata[7:0];
            OFS_CONTROL: s_d.ctl = bus_wdata[5:0];
            default: s_d.ctl = s_q.ctl;
          endcase
        end
      end
      ST_STROBE, ST_RELEASE: begin
        s_d.tmo_cnt = s_q.tmo_cnt + TMO_W'(1);
        if (s_q.tmo_cnt == TMO_W'(TIMEOUT_CYCLES - 1)) begin
          tmo_event = 1'b1;
          s_d.tmo_cnt = '0;
          s_d.strb_a = 1'b0;
          s_d.strb_d = 1'b0;
          s_d.timeout = 1'b1;
          s_d.st = ST_IDLE;
          s_d.ready = 1'b1;
          s_d.done = 1'b1;
          s_d.write_n = 1'b1;
          s_d.rdata = s_q.rbuf;
        end else if (s_q.st == ST_STROBE && busy_in) begin
          s_d.rbuf[{s_q.byte_idx, 3'h0} +: 8] = port_data_in;
          s_d.strb_a = 1'b0;
          s_d.strb_d = 1'b0;
          s_d.st = ST_RELEASE;
        end else if (s_q.st == ST_RELEASE && !busy_in) begin
          if (s_q.byte_idx == s_q.byte_last) begin
            s_d.st = ST_IDLE;
            s_d.ready = 1'b1;
            s_d.done = 1'b1;
            s_d.write_n = 1'b1;
            s_d.rdata = s_q.rbuf;
          end else begin
            s_d.byte_idx = s_q.byte_idx + 2'h1;
            s_d.pd_out = s_q.wbuf[{s_d.byte_idx, 3'h0} +: 8];
            s_d.strb_d = 1'b1;
            s_d.tmo_cnt = '0;
            s_d.st = ST_STROBE;
          end
        end
      end
      default: begin
        s_d.st = ST_IDLE;
        s_d.ready = 1'b1;
      end
    endcase
    // extended-mode latched request, set wins over read reset
    if (port_mode == MODE_EXTENDED && s_q.ctl[CTL_IRQ_EN_BIT] && ack_rise) begin
      s_d.irq_stat = 1'b0;
    end
    if (port_mode != MODE_EXTENDED) begin
      s_d.irq_stat = 1'b1;
    end
    s_d.irq_oe = s_d.ctl[CTL_IRQ_EN_BIT];
    case (port_mode)
      MODE_COMPAT: s_d.irq = !ack_in;
      MODE_EXTENDED: s_d.irq = !s_d.irq_stat;
      MODE_ENHANCED: s_d.irq = enh_mode ? (ack_rise || tmo_event) : !s_d.irq_stat;
      default: s_d.irq = !s_d.irq_stat;
    endcase
    s_d.irq = s_d.irq && s_d.ctl[CTL_IRQ_EN_BIT];
    if (s_d.st == ST_IDLE) begin
      s_d.pd_out = s_d.data_latch;
      s_d.pd_oe = !(ext_like && s_d.ctl[CTL_DIR_BIT]);
    end
    s_d.pin_stb = !s_d.ctl[CTL_STROBE_BIT];
    s_d.pin_feed = !s_d.ctl[CTL_FEED_BIT];
    s_d.pin_init = s_d.ctl[CTL_INIT_BIT];
    s_d.pin_sel = !s_d.ctl[CTL_SELECT_BIT];
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.ctl <= CTL_RESET;
      s_q.data_latch <= DATA_RESET;
      s_q.irq_stat <= 1'b1;
      s_q.ready <= 1'b1;
      s_q.write_n <= 1'b1;
      s_q.pd_oe <= 1'b1;
      s_q.pin_stb <= 1'b1;
      s_q.pin_feed <= 1'b1;
      s_q.pin_init <= 1'b1;
      s_q.pin_sel <= 1'b1;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign bus_rdata = s_q.rdata;
  assign bus_done = s_q.done;
  assign bus_ready = s_q.ready;
  assign port_data_lines = s_q.pd_out;
  assign port_data_oe = s_q.pd_oe;
  assign data_strobe_out = s_q.pin_stb;
  assign auto_feed_out = s_q.pin_feed;
  assign init_out = s_q.pin_init;
  assign select_request_out = s_q.pin_sel;
  assign control_oe = s_q.ctl_oe;
  assign address_strobe_out = s_q.strb_a;
  assign data_strobe_epp_out = s_q.strb_d;
  assign write_n_out = s_q.write_n;
  assign port_interrupt = s_q.irq;
  assign port_interrupt_oe = s_q.irq_oe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_status_paper;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && bus_rd && s_q.st == ST_IDLE && bus_addr == OFS_STATUS)
      |=> bus_done && bus_rdata[STS_PAPER_BIT] == $past(paper_end_in);
  endproperty
  a_status_paper: assert property (p_status_paper) else $error("paper bit wrong");
  property p_status_busy;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && bus_rd && s_q.st == ST_IDLE && bus_addr == OFS_STATUS)
      |=> bus_rdata[STS_BUSY_BIT] != $past(busy_in)
      && bus_rdata[STS_ACK_BIT] == $past(ack_in);
  endproperty
  a_status_busy: assert property (p_status_busy) else $error("busy or ack bit wrong");
  property p_ctl_rsvd;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && bus_rd && s_q.st == ST_IDLE && bus_addr == OFS_CONTROL && !enh_acc)
      |=> bus_rdata[7:6] == CTL_RSVD_VALUE;
  endproperty
  a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("reserved bits not one");
  property p_strobe_pin;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && bus_wr && s_q.st == ST_IDLE && bus_addr == OFS_CONTROL)
      |=> data_strobe_out == !$past(bus_wdata[0]) && init_out == $past(bus_wdata[2]);
  endproperty
  a_strobe_pin: assert property (p_strobe_pin) else $error("control pin wrong");
  property p_irq_float;
    @(posedge sys_clk) disable iff (rst)
    !s_q.ctl[CTL_IRQ_EN_BIT] |-> !port_interrupt_oe && !port_interrupt;
  endproperty
  a_irq_float: assert property (p_irq_float) else $error("interrupt not floated");
  property p_tmo_bound;
    @(posedge sys_clk) disable iff (rst)
    s_q.tmo_cnt < TMO_W'(TIMEOUT_CYCLES) && (bus_ready == (s_q.st == ST_IDLE));
  endproperty
  a_tmo_bound: assert property (p_tmo_bound) else $error("ready held too long");
  property p_abort_strobe;
    @(posedge sys_clk) disable iff (rst)
    $rose(s_q.timeout) && $past(s_q.st) != ST_IDLE
      |-> !address_strobe_out && !data_strobe_epp_out && bus_ready && bus_done;
  endproperty
  a_abort_strobe: assert property (p_abort_strobe) else $error("abort left strobe");
  property p_tmo_clear;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && bus_rd && s_q.st == ST_IDLE && bus_addr == OFS_STATUS) |=> !s_q.timeout;
  endproperty
  a_tmo_clear: assert property (p_tmo_clear) else $error("timeout flag kept");
  property p_data_pins;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && bus_wr && s_q.st == ST_IDLE && bus_addr == OFS_DATA_LATCH)
      |=> port_data_lines == $past(bus_wdata[7:0]);
  endproperty
  a_data_pins: assert property (p_data_pins) else $error("data pins wrong");
endmodule

// ==== core/pport_pkg.sv ====
// constants, offsets and types of the parallel port register block
package pport_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_DATA_LATCH = 3'h0;
  localparam logic [2:0] OFS_STATUS = 3'h1;
  localparam logic [2:0] OFS_CONTROL = 3'h2;
  localparam logic [2:0] OFS_TARGET = 3'h3;
  localparam logic [2:0] OFS_XFER0 = 3'h4;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int STS_TIMEOUT_BIT = 0;
  localparam int STS_IRQ_BIT = 2;
  localparam int STS_PAPER_BIT = 5;
  localparam int STS_ACK_BIT = 6;
  localparam int STS_BUSY_BIT = 7;
  localparam int CTL_STROBE_BIT = 0;
  localparam int CTL_FEED_BIT = 1;
  localparam int CTL_INIT_BIT = 2;
  localparam int CTL_SELECT_BIT = 3;
  localparam int CTL_IRQ_EN_BIT = 4;
  localparam int CTL_DIR_BIT = 5;
  // ----------------------------------------------------------------
  // reset values and fixed fields
  // ----------------------------------------------------------------
  localparam logic [5:0] CTL_RESET = 6'h04;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [1:0] CTL_RSVD_VALUE = 2'h3;
  localparam logic [7:0] UNMAPPED_VALUE = 8'hFF;
  localparam logic [9:0] BASE_NO_ENHANCED = 10'h3BC;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int TIMEOUT_US = 10;
  localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLK_MHZ + 1;
  localparam int TMO_W = $clog2(TIMEOUT_CYCLES + 1);
  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_COMPAT = 2'b00,
    MODE_EXTENDED = 2'b01,
    MODE_ENHANCED = 2'b10,
    MODE_EXT_CAP = 2'b11
  } port_mode_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_STROBE = 2'b01,
    ST_RELEASE = 2'b10
  } xfer_state_type;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_DWORD = 2'h2;
endpackage

// ==== verif/pport_periph.sv ====
// peripheral model answering the enhanced strobe handshake
`timescale 1ns/1ps
module pport_periph (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic address_strobe_out,
  input wire logic data_strobe_epp_out,
  input wire logic write_n_out,
  input wire logic [7:0] port_data_lines,
  input wire logic port_data_oe,
  input wire logic data_strobe_out,
  input wire logic auto_feed_out,
  input wire logic init_out,
  input wire logic select_request_out,
  input wire logic hold_busy,
  input wire logic stall,
  input wire logic [3:0] lat,
  input wire logic force_stb,
  output logic busy_in,
  output logic [7:0] port_data_in,
  output logic strobe_pin_in,
  output logic feed_pin_in,
  output logic init_pin_in,
  output logic select_pin_in
);
  logic hs_q;
  logic [3:0] wait_q;
  logic [7:0] last_q;
  logic [7:0] cap [0:15];
  logic capk [0:15];
  int cap_n;
  logic stb;
  // ----------------------------------------------------------------
  // pins seen by the port
  // ----------------------------------------------------------------
  assign stb = address_strobe_out | data_strobe_epp_out;
  assign busy_in = hs_q | hold_busy;
  // released lines show a changing pattern, never the last value outside a read strobe
  assign port_data_in = (stb & write_n_out & ~port_data_oe) ? 8'hC0 + cap_n[7:0] - {7'h0, hs_q} :
                        port_data_oe ? port_data_lines : ~last_q;
  assign strobe_pin_in = force_stb ? 1'b1 : data_strobe_out;
  assign feed_pin_in = auto_feed_out;
  assign init_pin_in = init_out;
  assign select_pin_in = select_request_out;
  // ----------------------------------------------------------------
  // handshake: wait high after lat cycles, low once strobe drops
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hs_q <= 1'b0;
      wait_q <= 4'h0;
      cap_n <= 0;
      last_q <= 8'h00;
    end else begin
      last_q <= port_data_in;
      if (stb && !hs_q) begin
        if (!stall && wait_q >= lat) begin
          hs_q <= 1'b1;
          cap[cap_n[3:0]] <= port_data_in;
          capk[cap_n[3:0]] <= address_strobe_out;
          cap_n <= cap_n + 1;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end else if (!stb) begin
        hs_q <= 1'b0;
        wait_q <= 4'h0;
      end
    end
  end
endmodule

// ==== verif/pport_regs_tb.sv ====
// self-checking bench of the parallel port registers
`timescale 1ns/1ps
module pport_regs_tb;
  import pport_pkg::*;
  logic sys_clk, rst, legacy_addressing, bus_rd, bus_wr, bus_done, bus_ready;
  logic paper_end_in, ack_in, busy_in, error_in, select_in, hold_busy, stall, force_stb;
  logic strobe_pin_in, feed_pin_in, init_pin_in, select_pin_in, port_data_oe;
  logic data_strobe_out, auto_feed_out, init_out, select_request_out, control_oe;
  logic address_strobe_out, data_strobe_epp_out, write_n_out, port_interrupt, port_interrupt_oe;
  port_mode_type port_mode;
  logic [9:0] base_addr;
  logic [2:0] bus_addr;
  logic [1:0] bus_size;
  logic [3:0] lat;
  logic [7:0] port_data_in, port_data_lines;
  logic [31:0] bus_wdata, bus_rdata, rd;
  int bad_count, cmp_count, lowcnt, irq_seen, n;
  pport_regs DUT (.sys_clk, .rst, .clk_en(1'b1), .port_mode, .legacy_addressing, .base_addr,
    .bus_rd, .bus_wr, .bus_addr, .bus_size, .bus_wdata, .bus_rdata, .bus_done, .bus_ready,
    .paper_end_in, .ack_in, .busy_in, .error_in, .select_in, .strobe_pin_in, .feed_pin_in,
    .init_pin_in, .select_pin_in, .port_data_in, .port_data_lines, .port_data_oe,
    .data_strobe_out, .auto_feed_out, .init_out, .select_request_out, .control_oe,
    .address_strobe_out, .data_strobe_epp_out, .write_n_out, .port_interrupt,
    .port_interrupt_oe);
  pport_periph periph (.sys_clk, .rst, .address_strobe_out, .data_strobe_epp_out, .write_n_out,
    .port_data_lines, .port_data_oe, .data_strobe_out, .auto_feed_out, .init_out,
    .select_request_out, .hold_busy, .stall, .lat, .force_stb, .busy_in, .port_data_in,
    .strobe_pin_in, .feed_pin_in, .init_pin_in, .select_pin_in);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask
  // one request, held for its taking edge, then a bounded wait for the answer
  task automatic bus(input logic wr, input logic [2:0] a, input logic [1:0] sz,
                     input logic [31:0] wd);
    int k;
    bus_wr = wr;
    bus_rd = ~wr;
    bus_addr = a;
    bus_size = sz;
    bus_wdata = wd;
    cyc(1);
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    if (bus_ready !== 1'b1) lowcnt++;
    for (k = 0; k < 1400 && bus_done !== 1'b1; k++) begin
      cyc(1);
      if (bus_ready !== 1'b1) lowcnt++;
      if (port_interrupt === 1'b1) irq_seen++;
    end
    if (bus_done !== 1'b1) begin
      bad_count++;
      complete_run();
    end
    rd = bus_rdata;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check("pins", {data_strobe_out, auto_feed_out, init_out, select_request_out}, 4'hF);
    bus(1'b0, OFS_CONTROL, SIZE_BYTE, 0);
    check("ctl_rst", rd[7:0], 8'hE4);
  endtask
  task automatic t_control();
    bus(1'b1, OFS_CONTROL, SIZE_BYTE, 32'h0B);
    check("pins_w", {control_oe, data_strobe_out, auto_feed_out, init_out, select_request_out}, 5'h10);
    bus(1'b0, OFS_CONTROL, SIZE_BYTE, 0);
    check("ctl_rd", rd[7:0], 8'hEB);
    force_stb = 1'b1;
    bus(1'b0, OFS_CONTROL, SIZE_BYTE, 0);
    check("ctl_pin", rd[7:0], 8'hEA);
    force_stb = 1'b0;
    bus(1'b1, OFS_CONTROL, SIZE_BYTE, 32'h04);
  endtask
  task automatic t_status();
    ack_in = 1'b0;
    paper_end_in = 1'b1;
    hold_busy = 1'b1;
    bus(1'b0, OFS_STATUS, SIZE_BYTE, 0);
    check("sts_a", rd[7:0], 8'h37);
    ack_in = 1'b1;
    paper_end_in = 1'b0;
    hold_busy = 1'b0;
    error_in = 1'b1;
    bus(1'b0, OFS_STATUS, SIZE_BYTE, 0);
    check("sts_b", rd[7:0], 8'hDF);
  endtask
  task automatic t_data();
    bus(1'b1, OFS_DATA_LATCH, SIZE_BYTE, 32'h5A);
    check("pd", {port_data_oe, port_data_lines}, 9'h15A);
    n = periph.cap_n;
    bus(1'b1, OFS_TARGET, SIZE_BYTE, 32'hA5);
    bus(1'b0, OFS_TARGET, SIZE_BYTE, 0);
    check("no_enh", {rd[7:0], periph.cap_n[7:0]}, {UNMAPPED_VALUE, n[7:0]});
  endtask
  task automatic t_irq();
    bus(1'b1, OFS_CONTROL, SIZE_BYTE, 32'h14);
    ack_in = 1'b0;
    cyc(2);
    check("irq_cmp", {port_interrupt_oe, port_interrupt}, 2'b11);
    ack_in = 1'b1;
    port_mode = MODE_EXTENDED;
    cyc(2);
    ack_in = 1'b0;
    cyc(2);
    ack_in = 1'b1;
    cyc(3);
    check("irq_ext", port_interrupt, 1'b1);
    bus(1'b0, OFS_STATUS, SIZE_BYTE, 0);
    cyc(1);
    check("irq_clr", port_interrupt, 1'b0);
    bus(1'b1, OFS_CONTROL, SIZE_BYTE, 32'h04);
    cyc(1);
    check("irq_off", port_interrupt_oe, 1'b0);
  endtask
  task automatic t_enh();
    port_mode = MODE_ENHANCED;
    bus(1'b1, OFS_CONTROL, SIZE_BYTE, 32'h14);
    bus(1'b0, OFS_STATUS, SIZE_BYTE, 0);
    check("tmo_entry", rd[0], 1'b0);
    check("busy_ok", rd[7], 1'b1);
    bus(1'b1, OFS_DATA_LATCH, SIZE_BYTE, 32'h3C);
    check("pd_enh", {port_data_oe, port_data_lines}, 9'h13C);
    n = periph.cap_n;
    bus(1'b1, OFS_TARGET, SIZE_BYTE, 32'hA5);
    check("addr_cyc", {periph.capk[n[3:0]], periph.cap[n[3:0]]}, 9'h1A5);
    check("wr_idle", write_n_out, 1'b1);
    bus(1'b1, OFS_XFER0, SIZE_DWORD, 32'h44332211);
    for (int i = 1; i < 5; i++) begin
      check("dword", {periph.capk[(n + i) % 16], periph.cap[(n + i) % 16]}, 9'h011 * i);
    end
    lat = 4'h0;
    bus(1'b0, OFS_XFER0, SIZE_WORD, 0);
    check("word_rd", rd[15:0], {8'hC6 + n[7:0], 8'hC5 + n[7:0]});
    irq_seen = 0;
    ack_in = 1'b0;
    cyc(2);
    ack_in = 1'b1;
    repeat (6) begin
      cyc(1);
      if (port_interrupt === 1'b1) irq_seen++;
    end
    check("irq_pulse", irq_seen, 1);
  endtask
  task automatic t_tmo();
    stall = 1'b1;
    lowcnt = 0;
    irq_seen = 0;
    bus(1'b1, OFS_XFER0, SIZE_BYTE, 32'h77);
    check("tmo_len", lowcnt > TIMEOUT_US * CLK_MHZ && lowcnt <= TIMEOUT_CYCLES + 2, 1);
    check("tmo_stb", {address_strobe_out, data_strobe_epp_out, bus_ready}, 3'b001);
    check("tmo_irq", irq_seen > 0, 1);
    stall = 1'b0;
    bus(1'b0, OFS_STATUS, SIZE_BYTE, 0);
    check("tmo_flag", rd[0], 1'b1);
    bus(1'b0, OFS_STATUS, SIZE_BYTE, 0);
    check("tmo_clr", rd[0], 1'b0);
  endtask
  task automatic t_base();
    n = periph.cap_n;
    base_addr = BASE_NO_ENHANCED;
    bus(1'b0, OFS_XFER0, SIZE_BYTE, 0);
    check("base_3bc", {rd[7:0], periph.cap_n[7:0]}, {UNMAPPED_VALUE, n[7:0]});
    base_addr = 10'h379;
    legacy_addressing = 1'b0;
    bus(1'b0, OFS_XFER0, SIZE_BYTE, 0);
    check("base_odd", {rd[7:0], periph.cap_n[7:0]}, {UNMAPPED_VALUE, n[7:0]});
    bus(1'b1, OFS_CONTROL, SIZE_BYTE, 32'h04);
    port_mode = MODE_EXT_CAP;
    cyc(2);
    check("irq_ecp", {port_interrupt_oe, port_interrupt}, 2'b00);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {bus_rd, bus_wr, bus_addr, bus_size, bus_wdata} = '0;
    {paper_end_in, error_in, hold_busy, stall, force_stb} = '0;
    {ack_in, select_in, legacy_addressing} = 3'b111;
    port_mode = MODE_COMPAT;
    base_addr = 10'h378;
    lat = 4'h2;
    bad_count = 0;
    cmp_count = 0;
    lowcnt = 0;
    irq_seen = 0;
    cyc(8);
    rst = 1'b0;
    t_reset();
    t_control();
    t_status();
    t_data();
    t_irq();
    t_enh();
    t_tmo();
    t_base();
    complete_run();
  end
endmodule
